// ### rtl/lec_pkg.sv
// Package for the lane 6/7 error counter control block.
// Assumes an 8-bit register port and a single 200 MHz clock.
package lec_pkg;
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned NUM_LINKS = 2;
  localparam int unsigned NUM_LANES = 2;
  localparam int unsigned NUM_CLS = 3;
  localparam int unsigned CNT_W = 8;
  localparam logic [11:0] LINK_PAGE_ADDR = 12'h300;
  localparam logic [11:0] LANE6_CTRL_ADDR = 12'h486;
  localparam logic [11:0] LANE7_CTRL_ADDR = 12'h487;
  localparam logic [11:0] TCH_ADDR = 12'h4a0;
  localparam logic [11:0] IRQ_STAT_ADDR = 12'h4a1;
  localparam logic [11:0] IRQ_MASK_ADDR = 12'h4a2;
  localparam logic [11:0] CNT_BASE_ADDR = 12'h4b0;
  localparam int unsigned ENA_LSB = 3;
  localparam int unsigned RST_LSB = 0;
  localparam logic [2:0] ENA_RESET = 3'h7;
  localparam logic [2:0] RST_RESET = 3'h7;
  localparam logic [2:0] TCH_RESET = 3'h7;
  localparam logic [7:0] CNT_MAX = 8'hff;
  // Class index: 2 unexpected control char, 1 not in table, 0 bad disparity
  localparam int unsigned CLS_UCC = 2;
  localparam int unsigned CLS_NIT = 1;
  localparam int unsigned CLS_BDE = 0;
endpackage

// ### rtl/lec_lane_error_counter_control.sv
// Paged control registers and error counters for lanes 6 and 7.
// Assumes error strobes come from decoder logic on the same clock, one per link, lane and class.
// Notes on behaviour
// RULE1: All lane enable/reset fields apply to the link picked by the page register.
// RULE2: Lane 6 enable field sits at bits 5:3, resets to all ones.
// RULE3: Lane 6 reset field sits at bits 2:0, resets to all ones, one per counter.
// RULE4: Enable bits: 5 unexpected control char, 4 not in table, 3 bad disparity.
// RULE5: Reset bits: 2 unexpected control char, 1 not in table, 0 bad disparity.
// RULE6: Lane 7 enable at bits 5:3 of 0x487, ones at reset, bits 7:6 read zero.
// RULE7: Lane 7 reset field at bits 2:0 of 0x487, ones at reset.
// RULE8: Counters are eight bits; hold at 0xff when hold set, else wrap.
// RULE9: Count only while enabled and not in reset; reset bit holds counter at zero.
//
// Chosen here: the strobed register port.
`timescale 1ns/100ps
module lec_lane_error_counter_control
  import lec_pkg::*;
(
  input wire logic mclk_in,
  input wire logic resetn_in,
  input wire logic [11:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [7:0] rdata_out,
  // Per link, per lane, per class error strobe: [link][lane][class]
  input wire logic [NUM_LINKS*NUM_LANES*NUM_CLS-1:0] err_in,
  output logic irq_out
);
  localparam int unsigned NCNT = NUM_LINKS * NUM_LANES * NUM_CLS;

  logic page_r, page_nxt;
  logic [5:0] ctrl_r [NUM_LINKS][NUM_LANES];
  logic [5:0] ctrl_nxt [NUM_LINKS][NUM_LANES];
  logic [2:0] tch_r [NUM_LINKS][NUM_LANES];
  logic [2:0] tch_nxt [NUM_LINKS][NUM_LANES];
  logic [CNT_W-1:0] cnt_r [NCNT];
  logic [CNT_W-1:0] cnt_nxt [NCNT];
  logic [NUM_LANES*NUM_CLS-1:0] stat_r, stat_nxt, mask_r, mask_nxt;
  logic [7:0] rdata_r, rdata_nxt;

  // Register writes; page selects which link's copy is reached
  always_comb begin
    page_nxt = page_r;
    mask_nxt = mask_r;
    ctrl_nxt = ctrl_r;
    tch_nxt = tch_r;
    if (wr_in) begin
      case (addr_in)
        LINK_PAGE_ADDR: page_nxt = wdata_in[0];
        LANE6_CTRL_ADDR: ctrl_nxt[page_r][0] = wdata_in[5:0]; // [RULE1] [RULE2] [RULE3]
        LANE7_CTRL_ADDR: ctrl_nxt[page_r][1] = wdata_in[5:0]; // [RULE1] [RULE6] [RULE7]
        TCH_ADDR: begin
          tch_nxt[page_r][0] = wdata_in[2:0];
          tch_nxt[page_r][1] = wdata_in[5:3];
        end
        IRQ_MASK_ADDR: mask_nxt = wdata_in[5:0];
        default: ;
      endcase
    end
  end

  // Counters: index = link*6 + lane*3 + class
  generate
    for (genvar i = 0; i < NCNT; i++) begin : g_cnt
      localparam int LK = i / (NUM_LANES * NUM_CLS);
      localparam int LN = (i / NUM_CLS) % NUM_LANES;
      localparam int CL = i % NUM_CLS;
      logic ena, rst, hold;
      assign ena = ctrl_r[LK][LN][ENA_LSB+CL]; // [RULE4]
      assign rst = ctrl_r[LK][LN][RST_LSB+CL]; // [RULE5]
      assign hold = tch_r[LK][LN][CL];
      always_comb begin
        cnt_nxt[i] = cnt_r[i];
        if (rst) begin
          cnt_nxt[i] = '0; // [RULE9]
        end else if (ena && err_in[i]) begin
          if (!(hold && cnt_r[i] == CNT_MAX)) begin
            cnt_nxt[i] = cnt_r[i] + 8'h01; // [RULE8] [RULE9]
          end
        end
      end
    end
  endgenerate

  // Status: a counter of either link reaching terminal count; read clears, set wins
  always_comb begin
    stat_nxt = stat_r;
    if (rd_in && addr_in == IRQ_STAT_ADDR) begin
      stat_nxt = '0;
    end
    for (int j = 0; j < NUM_LANES * NUM_CLS; j++) begin
      if (cnt_r[j] != CNT_MAX && cnt_nxt[j] == CNT_MAX) begin
        stat_nxt[j] = 1'b1;
      end
      if (cnt_r[j + NUM_LANES*NUM_CLS] != CNT_MAX &&
          cnt_nxt[j + NUM_LANES*NUM_CLS] == CNT_MAX) begin
        stat_nxt[j] = 1'b1;
      end
    end
  end

  // Read data, one cycle after the strobe
  always_comb begin
    rdata_nxt = 8'h00;
    if (rd_in) begin
      case (addr_in)
        LINK_PAGE_ADDR: rdata_nxt = {7'h00, page_r};
        LANE6_CTRL_ADDR: rdata_nxt = {2'h0, ctrl_r[page_r][0]}; // [RULE1] [RULE2]
        LANE7_CTRL_ADDR: rdata_nxt = {2'h0, ctrl_r[page_r][1]}; // [RULE6]
        TCH_ADDR: rdata_nxt = {2'h0, tch_r[page_r][1], tch_r[page_r][0]};
        IRQ_STAT_ADDR: rdata_nxt = {2'h0, stat_r};
        IRQ_MASK_ADDR: rdata_nxt = {2'h0, mask_r};
        default: begin
          for (int k = 0; k < NUM_LANES * NUM_CLS; k++) begin
            if (addr_in == CNT_BASE_ADDR + 12'(k)) begin
              rdata_nxt = cnt_r[k + (page_r ? NUM_LANES*NUM_CLS : 0)];
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      page_r <= 1'b0;
      mask_r <= '0;
      stat_r <= '0;
      rdata_r <= 8'h00;
      for (int a = 0; a < NUM_LINKS; a++) begin
        for (int b = 0; b < NUM_LANES; b++) begin
          ctrl_r[a][b] <= {ENA_RESET, RST_RESET};
          tch_r[a][b] <= TCH_RESET;
        end
      end
      for (int c = 0; c < NCNT; c++) begin
        cnt_r[c] <= '0;
      end
    end else begin
      page_r <= page_nxt;
      mask_r <= mask_nxt;
      stat_r <= stat_nxt;
      rdata_r <= rdata_nxt;
      ctrl_r <= ctrl_nxt;
      tch_r <= tch_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  assign rdata_out = rdata_r;
  assign irq_out = |(stat_r & mask_r);

  // Checks on control writes and readback
  a_paged_write: assert property ( // [RULE1]
    @(posedge mclk_in) disable iff (!resetn_in)
    wr_in && addr_in == LANE7_CTRL_ADDR
    |=> ctrl_r[$past(page_r)][1] == $past(wdata_in[5:0]))
    else $error("lane 7 control not written to paged link");
  a_paged_lane6: assert property ( // [RULE1]
    @(posedge mclk_in) disable iff (!resetn_in)
    wr_in && addr_in == LANE6_CTRL_ADDR
    |=> ctrl_r[$past(page_r)][0] == $past(wdata_in[5:0]))
    else $error("lane 6 control not written to paged link");
  a_other_page: assert property ( // [RULE1]
    @(posedge mclk_in) disable iff (!resetn_in)
    wr_in && addr_in == LANE7_CTRL_ADDR
    |=> ctrl_r[~$past(page_r)][1] == $past(ctrl_r[~page_r][1]))
    else $error("write reached the link that is not paged");
  a_lane6_read: assert property ( // [RULE2]
    @(posedge mclk_in) disable iff (!resetn_in)
    rd_in && addr_in == LANE6_CTRL_ADDR
    |=> rdata_out == {2'h0, $past(ctrl_r[page_r][0])})
    else $error("lane 6 control readback wrong");
  a_lane6_resv: assert property ( // [RULE2]
    @(posedge mclk_in) disable iff (!resetn_in)
    rd_in && addr_in == LANE6_CTRL_ADDR
    |=> rdata_out[7:6] == 2'h0)
    else $error("lane 6 spare bits read nonzero");
  a_lane7_read: assert property ( // [RULE6] [RULE7]
    @(posedge mclk_in) disable iff (!resetn_in)
    rd_in && addr_in == LANE7_CTRL_ADDR
    |=> rdata_out == {2'h0, $past(ctrl_r[page_r][1])})
    else $error("lane 7 control readback wrong");
  a_resv_zero: assert property ( // [RULE6]
    @(posedge mclk_in) disable iff (!resetn_in)
    rd_in && addr_in == LANE7_CTRL_ADDR
    |=> rdata_out[7:6] == 2'h0)
    else $error("reserved bits read nonzero");
  a_page_read: assert property ( // [RULE1]
    @(posedge mclk_in) disable iff (!resetn_in)
    rd_in && addr_in == LINK_PAGE_ADDR
    |=> rdata_out == {7'h00, $past(page_r)})
    else $error("page readback wrong");
  a_tch_read: assert property ( // [RULE8]
    @(posedge mclk_in) disable iff (!resetn_in)
    rd_in && addr_in == TCH_ADDR
    |=> rdata_out == {2'h0, $past(tch_r[page_r][1]), $past(tch_r[page_r][0])})
    else $error("hold readback wrong");
  a_cnt_read: assert property ( // [RULE1]
    @(posedge mclk_in) disable iff (!resetn_in)
    rd_in && addr_in == CNT_BASE_ADDR
    |=> rdata_out == $past(cnt_r[page_r ? NUM_LANES * NUM_CLS : 0]))
    else $error("paged counter readback wrong");
  a_stat_read: assert property ( // [RULE8]
    @(posedge mclk_in) disable iff (!resetn_in)
    rd_in && addr_in == IRQ_STAT_ADDR
    |=> rdata_out == {2'h0, $past(stat_r)})
    else $error("status readback wrong");
  a_mask_read: assert property (
    @(posedge mclk_in) disable iff (!resetn_in)
    rd_in && addr_in == IRQ_MASK_ADDR
    |=> rdata_out == {2'h0, $past(mask_r)})
    else $error("mask readback wrong");
  // Read data must not linger, software may poll without a strobe
  a_idle_zero: assert property (
    @(posedge mclk_in) disable iff (!resetn_in)
    !rd_in
    |=> rdata_out == 8'h00)
    else $error("read data stands without a read");

  // Fixed-index counter checks
  a_lane6_rst_hold: assert property ( // [RULE3]
    @(posedge mclk_in) disable iff (!resetn_in)
    ctrl_r[0][0][0]
    |=> cnt_r[0] == 8'h00)
    else $error("lane 6 counter not held in reset");
  a_ena_map: assert property ( // [RULE4]
    @(posedge mclk_in) disable iff (!resetn_in)
    !ctrl_r[0][0][5] && !ctrl_r[0][0][2]
    |=> cnt_r[2] == $past(cnt_r[2]))
    else $error("disabled counter moved");
  a_rst_map: assert property ( // [RULE5]
    @(posedge mclk_in) disable iff (!resetn_in)
    ctrl_r[1][1][1]
    |=> cnt_r[10] == 8'h00)
    else $error("reset bit does not clear its counter");
  a_lane7_rst: assert property ( // [RULE7]
    @(posedge mclk_in) disable iff (!resetn_in)
    ctrl_r[1][1][2]
    |=> cnt_r[11] == 8'h00)
    else $error("lane 7 reset does not clear");
  a_term_hold: assert property ( // [RULE8]
    @(posedge mclk_in) disable iff (!resetn_in)
    tch_r[0][0][0] && !ctrl_r[0][0][0] && cnt_r[0] == CNT_MAX
    |=> cnt_r[0] == CNT_MAX)
    else $error("held counter left terminal count");
  a_wrap: assert property ( // [RULE8]
    @(posedge mclk_in) disable iff (!resetn_in)
    !tch_r[0][0][0] && !ctrl_r[0][0][0] && ctrl_r[0][0][3] && err_in[0] &&
    cnt_r[0] == CNT_MAX |=> cnt_r[0] == 8'h00)
    else $error("counter did not wrap");
  a_count_step: assert property ( // [RULE9]
    @(posedge mclk_in) disable iff (!resetn_in)
    ctrl_r[0][0][3] && !ctrl_r[0][0][0] && err_in[0] && cnt_r[0] != CNT_MAX
    |=> cnt_r[0] == $past(cnt_r[0]) + 8'h01)
    else $error("enabled counter did not step");

  // Every counter, every link: the fixed-index checks above only sample one of each
  generate
    for (genvar g = 0; g < NCNT; g++) begin : g_chk
      localparam int LKC = g / (NUM_LANES * NUM_CLS);
      localparam int LNC = (g / NUM_CLS) % NUM_LANES;
      localparam int CLC = g % NUM_CLS;
      localparam int SBIT = g % (NUM_LANES * NUM_CLS);
      a_rst_zero: assert property ( // [RULE9]
        @(posedge mclk_in) disable iff (!resetn_in)
        ctrl_r[LKC][LNC][RST_LSB+CLC]
        |=> cnt_r[g] == 8'h00)
        else $error("counter not held at zero in reset");
      a_dis_still: assert property ( // [RULE4]
        @(posedge mclk_in) disable iff (!resetn_in)
        !ctrl_r[LKC][LNC][ENA_LSB+CLC] && !ctrl_r[LKC][LNC][RST_LSB+CLC]
        |=> cnt_r[g] == $past(cnt_r[g]))
        else $error("disabled counter moved");
      a_quiet_still: assert property ( // [RULE9]
        @(posedge mclk_in) disable iff (!resetn_in)
        !err_in[g] && !ctrl_r[LKC][LNC][RST_LSB+CLC]
        |=> cnt_r[g] == $past(cnt_r[g]))
        else $error("counter moved with no error");
      a_max_hold: assert property ( // [RULE8]
        @(posedge mclk_in) disable iff (!resetn_in)
        tch_r[LKC][LNC][CLC] && !ctrl_r[LKC][LNC][RST_LSB+CLC] && cnt_r[g] == CNT_MAX
        |=> cnt_r[g] == CNT_MAX)
        else $error("held counter left terminal count");
      a_roll_over: assert property ( // [RULE8]
        @(posedge mclk_in) disable iff (!resetn_in)
        !tch_r[LKC][LNC][CLC] && !ctrl_r[LKC][LNC][RST_LSB+CLC] &&
        ctrl_r[LKC][LNC][ENA_LSB+CLC] && err_in[g] && cnt_r[g] == CNT_MAX
        |=> cnt_r[g] == 8'h00)
        else $error("counter did not roll over");
      a_err_step: assert property ( // [RULE9]
        @(posedge mclk_in) disable iff (!resetn_in)
        ctrl_r[LKC][LNC][ENA_LSB+CLC] && !ctrl_r[LKC][LNC][RST_LSB+CLC] &&
        err_in[g] && cnt_r[g] != CNT_MAX
        |=> cnt_r[g] == $past(cnt_r[g]) + 8'h01)
        else $error("enabled counter did not step");
      a_stat_on_max: assert property ( // [RULE8]
        @(posedge mclk_in) disable iff (!resetn_in)
        cnt_r[g] == CNT_MAX && $past(cnt_r[g]) != CNT_MAX
        |-> stat_r[SBIT])
        else $error("status not set at terminal count");
    end
  endgenerate

  // Controls of a link only move when that link is paged
  generate
    for (genvar p = 0; p < NUM_LINKS * NUM_LANES; p++) begin : g_keep
      localparam int LKP = p / NUM_LANES;
      localparam int LNP = p % NUM_LANES;
      localparam logic [11:0] CADDR = (LNP == 1) ? LANE7_CTRL_ADDR : LANE6_CTRL_ADDR;
      a_ctrl_keep: assert property ( // [RULE1]
        @(posedge mclk_in) disable iff (!resetn_in)
        !(wr_in && addr_in == CADDR && page_r == 1'(LKP))
        |=> ctrl_r[LKP][LNP] == $past(ctrl_r[LKP][LNP]))
        else $error("control of an unpaged link changed");
      a_tch_keep: assert property ( // [RULE8]
        @(posedge mclk_in) disable iff (!resetn_in)
        !(wr_in && addr_in == TCH_ADDR && page_r == 1'(LKP))
        |=> tch_r[LKP][LNP] == $past(tch_r[LKP][LNP]))
        else $error("hold of an unpaged link changed");
    end
  endgenerate

  c_page_switch: cover property (@(posedge mclk_in) disable iff (!resetn_in)
    wr_in && addr_in == LINK_PAGE_ADDR ##1 wr_in && addr_in == LANE6_CTRL_ADDR);
  c_count: cover property (@(posedge mclk_in) disable iff (!resetn_in)
    cnt_r[0] == 8'h03);
  c_irq: cover property (@(posedge mclk_in) disable iff (!resetn_in) irq_out);
  c_wrap_seen: cover property (@(posedge mclk_in) disable iff (!resetn_in)
    cnt_r[1] == CNT_MAX ##1 cnt_r[1] == 8'h00);
  c_hold_seen: cover property (@(posedge mclk_in) disable iff (!resetn_in)
    cnt_r[0] == CNT_MAX ##1 cnt_r[0] == CNT_MAX);
endmodule

// ### tb/lec_link_model.sv
// Link source model: turns bench commands into error strobes.
// Assumes the clock and reset of the block under test.
`timescale 1ns/100ps
module lec_link_model (
  input wire logic mclk_in,
  input wire logic resetn_in,
  input wire logic fire_in,
  input wire logic [3:0] idx_in,
  output logic [11:0] err_out
);
  // One strobe a cycle while fired, so a burst of k cycles is k events
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in)
      err_out <= 12'h000;
    else
      err_out <= fire_in ? (12'h001 << idx_in) : 12'h000;
  end
endmodule

// ### tb/lane_error_counter_control_tb.sv
// Self-checking bench for the lane 6/7 error counter controls.
// Assumes the link model as error source and a 200 MHz clock.
`timescale 1ns/100ps
module lane_error_counter_control_tb;
  import lec_pkg::*;
  logic clk = 0, rstn = 0, wr = 0, rd = 0, fire = 0, irq;
  logic [11:0] addr = 12'h000, err, ca;
  logic [7:0] wd = 8'h00, rdata;
  logic [3:0] idx = 4'h0;
  logic [7:0] cm [2][2];
  int fails = 0, compares = 0, cyc = 0, ln, la, c, n;
  lec_lane_error_counter_control i_dut (.mclk_in(clk), .resetn_in(rstn), .addr_in(addr),
    .wdata_in(wd), .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .err_in(err), .irq_out(irq));
  lec_link_model i_link (.mclk_in(clk), .resetn_in(rstn), .fire_in(fire), .idx_in(idx),
    .err_out(err));
  initial begin
    forever #2.5 clk = ~clk;
  end
  task automatic chk(input string nm, input logic [7:0] s, input logic [7:0] e);
    compares++;
    if (s !== e) begin
      fails++;
      $display("CHECK FAILED %s exp %h seen %h", nm, e, s);
    end
  endtask
  // Writes leave an idle cycle so a strobe is never set twice at one edge
  task automatic wrr(input logic [11:0] a, input logic [7:0] d);
    addr <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [7:0] e);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk("rdata", rdata, e);
    @(posedge clk);
  endtask
  task automatic burst(input int i, input int k);
    idx <= i[3:0];
    fire <= 1'b1;
    repeat (k) @(posedge clk);
    fire <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
  function automatic logic [11:0] ctl(input int l);
    return l ? LANE7_CTRL_ADDR : LANE6_CTRL_ADDR;
  endfunction
  task print_verdict;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      print_verdict;
    end
  end
  initial begin
    void'($urandom(26));
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    for (int l = 0; l < 2; l++) begin
      wrr(LINK_PAGE_ADDR, l[7:0]);
      for (int a = 0; a < 2; a++) begin
        rdc(ctl(a), 8'h3f);
        cm[l][a] = 8'h3f;
      end
    end
    wrr(LANE7_CTRL_ADDR, 8'hff);
    rdc(LANE7_CTRL_ADDR, 8'h3f);
    rdc(12'h123, 8'h00);
    repeat (8) begin
      ln = $urandom % 2;
      la = $urandom % 2;
      c = $urandom % 3;
      n = 1 + $urandom % 9;
      ca = CNT_BASE_ADDR + 12'(la * 3 + c);
      wrr(LINK_PAGE_ADDR, ln[7:0]);
      wrr(ctl(la), 8'h38);
      burst(ln * 6 + la * 3 + c, n);
      rdc(ca, n[7:0]);
      wrr(ctl(la), 8'h38 ^ (8'h08 << c));
      burst(ln * 6 + la * 3 + c, 2);
      rdc(ca, n[7:0]);
      cm[ln][la] = 8'h38 | (8'h01 << c);
      wrr(ctl(la), cm[ln][la]);
      rdc(ca, 8'h00);
    end
    for (int l = 0; l < 2; l++) begin
      wrr(LINK_PAGE_ADDR, l[7:0]);
      for (int a = 0; a < 2; a++)
        rdc(ctl(a), cm[l][a]);
    end
    wrr(LINK_PAGE_ADDR, 8'h00);
    wrr(LANE6_CTRL_ADDR, 8'h38);
    burst(0, 300);
    rdc(CNT_BASE_ADDR, 8'hff);
    chk("irq", {7'h00, irq}, 8'h00);
    wrr(IRQ_MASK_ADDR, 8'h01);
    chk("irq", {7'h00, irq}, 8'h01);
    wrr(LANE6_CTRL_ADDR, 8'h39);
    rdc(IRQ_STAT_ADDR, 8'h01);
    chk("irq", {7'h00, irq}, 8'h00);
    wrr(TCH_ADDR, 8'h00);
    wrr(LANE6_CTRL_ADDR, 8'h38);
    burst(1, 258);
    rdc(CNT_BASE_ADDR + 12'h001, 8'h02);
    rdc(IRQ_STAT_ADDR, 8'h02);
    print_verdict;
  end
endmodule
